// ### logic/dsbc_pkg.sv
// constants, register map and types of the dual state bus controller
package dsbc_pkg;
    localparam int APB_AW = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLOCK_CONFIG_ONE = 8'h01;
    localparam logic [7:0] IDX_BUS_CONTROL = 8'h09;
    localparam logic [7:0] IDX_MEMORY_WAIT_RECOVERY = 8'h12;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] RST_CLOCK_CONFIG_ONE = 8'h00;
    localparam logic [7:0] RST_BUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_MEMORY_WAIT_RECOVERY = 8'h00;
    // bus_control fields
    localparam int BC_BUS_CONNECT = 0;
    localparam int BC_BUS_RESET_FORCE = 2;
    localparam int BC_FULL_IO_DECODE = 3;
    // memory_wait_recovery fields
    localparam int MWR_ROM_RECOVERY_DISABLE = 6;
    localparam int MWR_XIO_RECOVERY_DISABLE = 7;
    // clock_config_one fields
    localparam int CC_CPU_SRC = 0;
    localparam int CC_CPU_DIV_LO = 1;
    localparam int CC_ISA_SRC = 4;
    localparam int CC_ISA_DIV_LO = 5;
    localparam int CC_FAST_VISIBLE_ENABLE = 7;
    // divisor codes
    localparam logic [1:0] DIV_CODE_4 = 2'h0;
    localparam logic [1:0] DIV_CODE_1 = 2'h1;
    localparam logic [1:0] DIV_CODE_2 = 2'h2;
    localparam logic [1:0] DIV_CODE_X = 2'h3;
    localparam logic [4:0] CPU_DIV_X = 5'h10;
    localparam logic [4:0] ISA_DIV_X = 5'h03;
    // io decode
    localparam int IO_LOW_BITS = 10;
    localparam int IO_ADDR_W = 16;
    // sync ticks before an unsynced compat cycle
    localparam logic [3:0] UNSYNC_TICKS = 4'h2;
    // ticks of the state machine clock per cycle clock
    localparam logic [3:0] TICKS_PER_CYCLE = 4'h2;

    typedef enum logic [1:0] {
        DSBC_SYNC_EQUAL = 2'h0,
        DSBC_SYNC_HALF = 2'h1,
        DSBC_UNSYNCED = 2'h2,
        DSBC_FAST_VISIBLE = 2'h3
    } dsbc_mode_type;

    typedef enum logic [1:0] {
        DSBC_BUS_S = 2'h0,
        DSBC_BUS_M = 2'h1,
        DSBC_BUS_X = 2'h2
    } dsbc_bus_type;

    typedef enum logic [1:0] {
        DSBC_KIND_OTHER = 2'h0,
        DSBC_KIND_ROM = 2'h1,
        DSBC_KIND_XIO = 2'h2
    } dsbc_kind_type;

    typedef enum logic [3:0] {
        DSBC_IDLE = 4'h0,
        DSBC_STAT = 4'h1,
        DSBC_F_CMD = 4'h5,
        DSBC_A_SYNC = 4'h3,
        DSBC_A_DLY = 4'h2,
        DSBC_A_CMD = 4'h6,
        DSBC_RECOV = 4'h7,
        DSBC_DONE = 4'h4
    } dsbc_state_type;
endpackage

// ### logic/dsbc_tick_div.sv
// enable-pulse divider that makes the state machine clock tick
module dsbc_tick_div #(
    parameter int W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] ratio,
    output logic tick
);
    logic [W-1:0] cnt_r;

    // ratio of one gives a tick every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (cnt_r + W'(1) >= ratio) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign tick = (cnt_r + W'(1) >= ratio);
endmodule

// ### logic/dsbc_top.sv
// dual state bus controller: decision unit, one shared cycle machine, router, apb registers
module dsbc_top #(
    parameter int DW = 16,
    parameter logic [2:0] DEF_WAITS = 3'h0,
    parameter logic [1:0] DEF_DELAYS = 2'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsbc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cyc_start,
    input wire logic cyc_write,
    input wire logic cyc_io,
    input wire logic cyc_word,
    input wire logic [dsbc_pkg::IO_ADDR_W-1:0] cyc_addr,
    input wire logic [DW-1:0] cyc_wdata,
    output logic [DW-1:0] cyc_rdata,
    output logic cyc_ready,
    input wire logic fb_valid,
    input wire logic fb_fast,
    input wire logic fb_wide,
    input wire logic [2:0] fb_waits,
    input wire logic [1:0] fb_delays,
    input wire logic [1:0] fb_bus,
    input wire logic [1:0] fb_kind,
    output logic cmd_n,
    output logic tgt_a0,
    output logic [DW-1:0] tgt_wdata,
    input wire logic [DW-1:0] tgt_rdata,
    output logic io_addr_ok,
    output logic [dsbc_pkg::IO_LOW_BITS-1:0] io_dec_addr,
    output logic sbus_buf_en,
    output logic sbus_buf_dir,
    output logic mbus_buf_en,
    output logic mbus_buf_dir,
    output logic xbus_buf_en,
    output logic xbus_buf_dir,
    output logic ext_buf_en,
    output logic ext_buf_dir,
    output logic fast_sel,
    input wire logic power_ok_in,
    output logic expansion_reset_out
);
    localparam int HB = DW / 2;

    logic [7:0] clock_config_one_r;
    logic [7:0] bus_control_r;
    logic [7:0] memory_wait_recovery_r;
    dsbc_pkg::dsbc_state_type state_r;
    dsbc_pkg::dsbc_mode_type mode;
    logic [3:0] cnt_r;
    logic req_write_r, req_word_r, req_a0_r, half2_r;
    logic sel_fast_r, sel_wide_r;
    logic [2:0] sel_waits_r;
    logic [1:0] sel_delays_r;
    dsbc_pkg::dsbc_bus_type sel_bus_r;
    dsbc_pkg::dsbc_kind_type sel_kind_r;
    logic [DW-1:0] wdata_r, rdata_r, tgt_wdata_r;
    logic cmd_n_r, tgt_a0_r, io_ok_r;
    logic [dsbc_pkg::IO_LOW_BITS-1:0] io_dec_r;
    logic pwr_s1_r, pwr_s2_r, rst_out_r;
    logic sbus_en_r, mbus_en_r, xbus_en_r, ext_en_r, dir_r;
    logic tick, cyc_phase_r, cyc_tick;
    logic [4:0] cpu_div, isa_div;
    logic apb_wr, hit_ok, recov_need, split, route_hi;
    logic [3:0] cmd_len;

    // divisor decode and clocking mode
    always_comb begin
        unique case (clock_config_one_r[dsbc_pkg::CC_CPU_DIV_LO +: 2])
            dsbc_pkg::DIV_CODE_4: cpu_div = 5'h04;
            dsbc_pkg::DIV_CODE_1: cpu_div = 5'h01;
            dsbc_pkg::DIV_CODE_2: cpu_div = 5'h02;
            dsbc_pkg::DIV_CODE_X: cpu_div = dsbc_pkg::CPU_DIV_X;
        endcase
        unique case (clock_config_one_r[dsbc_pkg::CC_ISA_DIV_LO +: 2])
            dsbc_pkg::DIV_CODE_4: isa_div = 5'h04;
            dsbc_pkg::DIV_CODE_1: isa_div = 5'h01;
            dsbc_pkg::DIV_CODE_2: isa_div = 5'h02;
            dsbc_pkg::DIV_CODE_X: isa_div = dsbc_pkg::ISA_DIV_X;
        endcase
    end

    always_comb begin
        mode = dsbc_pkg::DSBC_UNSYNCED;
        if (clock_config_one_r[dsbc_pkg::CC_CPU_SRC] ==
                clock_config_one_r[dsbc_pkg::CC_ISA_SRC]) begin
            if (cpu_div == isa_div) begin
                mode = clock_config_one_r[dsbc_pkg::CC_FAST_VISIBLE_ENABLE] ?
                    dsbc_pkg::DSBC_FAST_VISIBLE : dsbc_pkg::DSBC_SYNC_EQUAL;
            end else if (isa_div == {cpu_div[3:0], 1'b0}) begin
                mode = dsbc_pkg::DSBC_SYNC_HALF;
            end
        end
    end

    // pclk stands in for the shared source; only the isa ratio matters here
    dsbc_tick_div #(.W(5)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ratio(isa_div),
        .tick(tick)
    );

    // cycle clock phase: every second state machine tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_phase_r <= 1'b0;
        end else if (tick) begin
            cyc_phase_r <= ~cyc_phase_r;
        end
    end
    assign cyc_tick = tick & cyc_phase_r;

    // apb slave, zero wait, unmapped answers slverr
    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    always_comb begin
        hit_ok = 1'b1;
        prdata = 32'h0000_0000;
        unique case (paddr)
            {dsbc_pkg::IDX_CLOCK_CONFIG_ONE[5:0], 2'b00}: prdata[7:0] = clock_config_one_r;
            {dsbc_pkg::IDX_BUS_CONTROL[5:0], 2'b00}: prdata[7:0] = bus_control_r;
            {dsbc_pkg::IDX_MEMORY_WAIT_RECOVERY[5:0], 2'b00}:
                prdata[7:0] = memory_wait_recovery_r;
            {dsbc_pkg::IDX_STATUS[5:0], 2'b00}:
                prdata[9:0] = {rst_out_r, fast_sel, mode, state_r, sel_fast_r, half2_r};
            default: hit_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_config_one_r <= dsbc_pkg::RST_CLOCK_CONFIG_ONE;
            bus_control_r <= dsbc_pkg::RST_BUS_CONTROL;
            memory_wait_recovery_r <= dsbc_pkg::RST_MEMORY_WAIT_RECOVERY;
        end else if (apb_wr) begin
            if (paddr == {dsbc_pkg::IDX_CLOCK_CONFIG_ONE[5:0], 2'b00}) begin
                clock_config_one_r <= pwdata[7:0];
            end
            if (paddr == {dsbc_pkg::IDX_BUS_CONTROL[5:0], 2'b00}) begin
                bus_control_r <= pwdata[7:0];
            end
            if (paddr == {dsbc_pkg::IDX_MEMORY_WAIT_RECOVERY[5:0], 2'b00}) begin
                memory_wait_recovery_r <= pwdata[7:0];
            end
        end
    end

    // expansion bus reset: power ok is a pin, synchronised first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_s1_r <= 1'b0;
            pwr_s2_r <= 1'b0;
            rst_out_r <= 1'b1;
        end else begin
            pwr_s1_r <= power_ok_in;
            pwr_s2_r <= pwr_s1_r;
            rst_out_r <= ~pwr_s2_r | bus_control_r[dsbc_pkg::BC_BUS_RESET_FORCE];
        end
    end
    assign expansion_reset_out = rst_out_r;

    // sizing and recovery decisions for the latched cycle
    assign split = req_word_r & ~sel_wide_r;
    assign route_hi = ~sel_wide_r & (half2_r | (~req_word_r & req_a0_r));
    assign cmd_len = 4'((sel_waits_r + 3'h1) * dsbc_pkg::TICKS_PER_CYCLE - 4'h1);
    always_comb begin
        recov_need = 1'b0;
        if (sel_kind_r == dsbc_pkg::DSBC_KIND_ROM) begin
            recov_need = ~memory_wait_recovery_r[dsbc_pkg::MWR_ROM_RECOVERY_DISABLE];
        end else if (sel_kind_r == dsbc_pkg::DSBC_KIND_XIO) begin
            recov_need = ~memory_wait_recovery_r[dsbc_pkg::MWR_XIO_RECOVERY_DISABLE];
        end
    end

    // request and feedback capture, one selection per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_write_r <= 1'b0;
            req_word_r <= 1'b0;
            req_a0_r <= 1'b0;
            wdata_r <= '0;
            sel_fast_r <= 1'b0;
            sel_wide_r <= 1'b0;
            sel_waits_r <= 3'h0;
            sel_delays_r <= 2'h0;
            sel_bus_r <= dsbc_pkg::DSBC_BUS_S;
            sel_kind_r <= dsbc_pkg::DSBC_KIND_OTHER;
            io_ok_r <= 1'b0;
            io_dec_r <= '0;
        end else if (state_r == dsbc_pkg::DSBC_IDLE && cyc_start) begin
            req_write_r <= cyc_write;
            req_word_r <= cyc_word;
            req_a0_r <= cyc_addr[0];
            wdata_r <= cyc_wdata;
            io_dec_r <= cyc_addr[dsbc_pkg::IO_LOW_BITS-1:0];
            io_ok_r <= ~cyc_io | ~bus_control_r[dsbc_pkg::BC_FULL_IO_DECODE] |
                (cyc_addr[dsbc_pkg::IO_ADDR_W-1:dsbc_pkg::IO_LOW_BITS] == '0);
            if (fb_valid) begin
                sel_fast_r <= fb_fast;
                sel_wide_r <= fb_wide;
                sel_waits_r <= fb_waits;
                sel_delays_r <= fb_delays;
                sel_bus_r <= dsbc_pkg::dsbc_bus_type'(fb_bus);
                sel_kind_r <= dsbc_pkg::dsbc_kind_type'(fb_kind);
            end else begin
                // silence on feedback means an expansion cycle
                sel_fast_r <= 1'b0;
                sel_wide_r <= 1'b1;
                sel_waits_r <= DEF_WAITS;
                sel_delays_r <= DEF_DELAYS;
                sel_bus_r <= dsbc_pkg::DSBC_BUS_S;
                sel_kind_r <= dsbc_pkg::DSBC_KIND_OTHER;
            end
        end
    end

    // cycle state machine shared by fast and compat paths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= dsbc_pkg::DSBC_IDLE;
            cnt_r <= 4'h0;
            half2_r <= 1'b0;
        end else begin
            unique case (state_r)
                dsbc_pkg::DSBC_IDLE: begin
                    half2_r <= 1'b0;
                    if (cyc_start) begin
                        state_r <= dsbc_pkg::DSBC_STAT;
                    end
                end
                dsbc_pkg::DSBC_STAT: begin
                    if (sel_fast_r) begin
                        state_r <= dsbc_pkg::DSBC_F_CMD;
                        cnt_r <= {1'b0, sel_waits_r};
                    end else begin
                        state_r <= dsbc_pkg::DSBC_A_SYNC;
                        cnt_r <= (mode == dsbc_pkg::DSBC_UNSYNCED) ?
                            dsbc_pkg::UNSYNC_TICKS : 4'h0;
                    end
                end
                dsbc_pkg::DSBC_F_CMD: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= recov_need ? dsbc_pkg::DSBC_RECOV :
                            dsbc_pkg::DSBC_DONE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                dsbc_pkg::DSBC_A_SYNC: begin
                    // equal clocks start at once, half rate waits for the cycle phase
                    if (mode == dsbc_pkg::DSBC_SYNC_HALF) begin
                        if (cyc_tick) begin
                            state_r <= dsbc_pkg::DSBC_A_DLY;
                            cnt_r <= {2'b00, sel_delays_r};
                        end
                    end else if (mode == dsbc_pkg::DSBC_UNSYNCED) begin
                        if (tick) begin
                            if (cnt_r == 4'h0) begin
                                state_r <= dsbc_pkg::DSBC_A_DLY;
                                cnt_r <= {2'b00, sel_delays_r};
                            end else begin
                                cnt_r <= cnt_r - 4'h1;
                            end
                        end
                    end else begin
                        state_r <= dsbc_pkg::DSBC_A_DLY;
                        cnt_r <= {2'b00, sel_delays_r};
                    end
                end
                dsbc_pkg::DSBC_A_DLY: begin
                    if (tick) begin
                        if (cnt_r == 4'h0) begin
                            state_r <= dsbc_pkg::DSBC_A_CMD;
                            cnt_r <= cmd_len;
                        end else begin
                            cnt_r <= cnt_r - 4'h1;
                        end
                    end
                end
                dsbc_pkg::DSBC_A_CMD: begin
                    if (tick) begin
                        if (cnt_r != 4'h0) begin
                            cnt_r <= cnt_r - 4'h1;
                        end else if (split && !half2_r) begin
                            half2_r <= 1'b1;
                            state_r <= dsbc_pkg::DSBC_A_DLY;
                            cnt_r <= {2'b00, sel_delays_r};
                        end else begin
                            state_r <= recov_need ? dsbc_pkg::DSBC_RECOV :
                                dsbc_pkg::DSBC_DONE;
                        end
                    end
                end
                dsbc_pkg::DSBC_RECOV: state_r <= dsbc_pkg::DSBC_DONE;
                dsbc_pkg::DSBC_DONE: state_r <= dsbc_pkg::DSBC_IDLE;
                default: state_r <= dsbc_pkg::DSBC_IDLE;
            endcase
        end
    end

    // synchronous ready, one cycle, after command and any recovery
    assign cyc_ready = (state_r == dsbc_pkg::DSBC_DONE);

    // command strobe, address bit and lanes, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_n_r <= 1'b1;
            tgt_a0_r <= 1'b0;
            tgt_wdata_r <= '0;
            rdata_r <= '0;
        end else begin
            cmd_n_r <= ~((state_r == dsbc_pkg::DSBC_STAT && sel_fast_r) ||
                (state_r == dsbc_pkg::DSBC_F_CMD && cnt_r != 4'h0) ||
                (state_r == dsbc_pkg::DSBC_A_DLY && tick && cnt_r == 4'h0) ||
                (state_r == dsbc_pkg::DSBC_A_CMD && !(tick && cnt_r == 4'h0)));
            tgt_a0_r <= req_a0_r ^ half2_r;
            tgt_wdata_r[DW-1:HB] <= wdata_r[DW-1:HB];
            tgt_wdata_r[HB-1:0] <= route_hi ? wdata_r[DW-1:HB] : wdata_r[HB-1:0];
            // read data of a disconnected expansion cycle is taken but meaningless
            if ((state_r == dsbc_pkg::DSBC_F_CMD && cnt_r == 4'h0) ||
                    (state_r == dsbc_pkg::DSBC_A_CMD && tick && cnt_r == 4'h0)) begin
                if (sel_wide_r) begin
                    rdata_r <= tgt_rdata;
                end else if (route_hi) begin
                    rdata_r[DW-1:HB] <= tgt_rdata[HB-1:0];
                end else begin
                    rdata_r[HB-1:0] <= tgt_rdata[HB-1:0];
                end
            end
        end
    end

    // router: buffers follow the latched target bus from status through command, not in recovery; s bus and ext buffers only with bus connect set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sbus_en_r <= 1'b0;
            mbus_en_r <= 1'b0;
            xbus_en_r <= 1'b0;
            ext_en_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            sbus_en_r <= 1'b0;
            mbus_en_r <= 1'b0;
            xbus_en_r <= 1'b0;
            ext_en_r <= 1'b0;
            dir_r <= ~req_write_r;
            if (state_r != dsbc_pkg::DSBC_IDLE && state_r != dsbc_pkg::DSBC_DONE &&
                    state_r != dsbc_pkg::DSBC_RECOV) begin
                unique case (sel_bus_r)
                    dsbc_pkg::DSBC_BUS_S: begin
                        sbus_en_r <= bus_control_r[dsbc_pkg::BC_BUS_CONNECT];
                        ext_en_r <= bus_control_r[dsbc_pkg::BC_BUS_CONNECT];
                    end
                    dsbc_pkg::DSBC_BUS_M: mbus_en_r <= 1'b1;
                    dsbc_pkg::DSBC_BUS_X: xbus_en_r <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    assign cmd_n = cmd_n_r;
    assign tgt_a0 = tgt_a0_r;
    assign tgt_wdata = tgt_wdata_r;
    assign cyc_rdata = rdata_r;
    assign io_addr_ok = io_ok_r;
    assign io_dec_addr = io_dec_r;
    assign sbus_buf_en = sbus_en_r;
    assign mbus_buf_en = mbus_en_r;
    assign xbus_buf_en = xbus_en_r;
    assign ext_buf_en = ext_en_r;
    assign sbus_buf_dir = dir_r;
    assign mbus_buf_dir = dir_r;
    assign xbus_buf_dir = dir_r;
    assign ext_buf_dir = dir_r;
    assign fast_sel = sel_fast_r;
endmodule

// ### testbench/dsbc_checker.sv
// port relation checker of the bus controller
module dsbc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cyc_start,
    input wire logic cyc_ready,
    input wire logic cyc_write,
    input wire logic cmd_n,
    input wire logic fb_valid,
    input wire logic fb_fast,
    input wire logic [2:0] fb_waits,
    input wire logic [1:0] fb_kind,
    input wire logic fast_sel,
    input wire logic [1:0] fb_bus,
    input wire logic mbus_buf_en,
    input wire logic xbus_buf_en,
    input wire logic sbus_buf_dir,
    input wire logic mbus_buf_dir,
    input wire logic xbus_buf_dir,
    input wire logic ext_buf_dir,
    input wire logic [dsbc_pkg::IO_LOW_BITS-1:0] io_dec_addr,
    input wire logic [dsbc_pkg::IO_ADDR_W-1:0] cyc_addr,
    input wire logic io_addr_ok,
    input wire logic power_ok_in,
    input wire logic expansion_reset_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a fast request taken while idle, no recovery kind
    sequence s_go(logic [2:0] w);
        cyc_start && cmd_n && !cyc_ready && fb_valid && fb_fast && fb_waits == w &&
            fb_kind == 2'h0;
    endsequence
    property p_fast0; s_go(3'h0) |-> ##2 !cmd_n ##1 (cyc_ready && cmd_n); endproperty
    a_fast0: assert property (p_fast0) else $error("fast zero wait cycle timing wrong");
    property p_fast1; s_go(3'h1) |-> ##2 !cmd_n[*2] ##1 cyc_ready; endproperty
    a_fast1: assert property (p_fast1) else $error("one wait state not one cycle longer");
    property p_ready_once; cyc_ready |=> !cyc_ready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready longer than a cycle");
    property p_sel;
        cyc_start && fb_valid && cmd_n && !cyc_ready |=> fast_sel == $past(fb_fast);
    endproperty
    a_sel: assert property (p_sel) else $error("machine choice differs from feedback");
    property p_nofb; cyc_start && !fb_valid && cmd_n && !cyc_ready |=> !fast_sel; endproperty
    a_nofb: assert property (p_nofb) else $error("fast machine without feedback");
    property p_dec; !cmd_n |-> io_dec_addr == cyc_addr[9:0]; endproperty
    a_dec: assert property (p_dec) else $error("decode address not low ten bits");
    property p_ok; !cmd_n && cyc_addr[15:10] == 6'h00 |-> io_addr_ok; endproperty
    a_ok: assert property (p_ok) else $error("select refused with zero upper bits");
    property p_pwr; !power_ok_in |-> ##[1:4] expansion_reset_out; endproperty
    a_pwr: assert property (p_pwr) else $error("reset out not raised by power low");
    property p_route;
        !cmd_n && fb_valid |-> mbus_buf_en == (fb_bus == 2'h1) && xbus_buf_en == (fb_bus == 2'h2);
    endproperty
    a_route: assert property (p_route) else $error("buffer enable not the target bus");
    property p_dir;
        !cmd_n |-> {sbus_buf_dir, mbus_buf_dir, xbus_buf_dir, ext_buf_dir} == {4{!cyc_write}};
    endproperty
    a_dir: assert property (p_dir) else $error("buffer direction wrong");
endmodule

bind dsbc_top dsbc_checker dsbc_checker_i (.pclk, .presetn, .cyc_start, .cyc_ready, .cmd_n,
    .fb_valid, .fb_fast, .fb_waits, .fb_kind, .fast_sel, .io_dec_addr, .cyc_addr, .io_addr_ok,
    .power_ok_in, .expansion_reset_out, .cyc_write, .fb_bus, .mbus_buf_en, .xbus_buf_en,
    .sbus_buf_dir, .mbus_buf_dir, .xbus_buf_dir, .ext_buf_dir);

// ### testbench/dsbc_partner.sv
// far side target model: narrow lane answers and write capture
module dsbc_partner (
    input wire logic pclk,
    input wire logic cmd_n,
    input wire logic tgt_a0,
    input wire logic [15:0] tgt_wdata,
    input wire logic [7:0] rd_lo,
    input wire logic [7:0] rd_hi,
    output logic [15:0] tgt_rdata,
    output logic [7:0] wr_lo,
    output logic [7:0] wr_hi
);
    logic [15:0] last_r;
    always_ff @(posedge pclk) begin
        last_r <= tgt_rdata;
        if (!cmd_n && tgt_a0) wr_hi <= tgt_wdata[7:0];
        if (!cmd_n && !tgt_a0) wr_lo <= tgt_wdata[7:0];
    end
    // released lines flip every cycle so stale data never looks good
    assign tgt_rdata = cmd_n ? ~last_r : (tgt_a0 ? {rd_lo, rd_hi} : {rd_hi, rd_lo});
endmodule

// ### testbench/dual_state_bus_controller_test.sv
// testbench of the dual state bus controller
module dual_state_bus_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cyc_start, cyc_write, cyc_io;
    logic cyc_word, cyc_ready, fb_valid, fb_fast, fb_wide, cmd_n, tgt_a0, io_addr_ok, ext_buf_en;
    logic power_ok_in, expansion_reset_out, sbus_buf_en, ok, err;
    logic [1:0] ext;
    logic [7:0] paddr, rd_lo, rd_hi, wr_lo, wr_hi;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cyc_addr, cyc_wdata, cyc_rdata, tgt_wdata, tgt_rdata;
    logic [2:0] fb_waits;
    logic [1:0] fb_delays, fb_bus, fb_kind;
    int errors, n_compared, n, fall, len, f0, l0;
    dsbc_top dsbc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cyc_start, .cyc_write, .cyc_io, .cyc_word, .cyc_addr, .cyc_wdata,
        .cyc_rdata, .cyc_ready, .fb_valid, .fb_fast, .fb_wide, .fb_waits, .fb_delays, .fb_bus,
        .fb_kind, .cmd_n, .tgt_a0, .tgt_wdata, .tgt_rdata, .io_addr_ok, .io_dec_addr(),
        .sbus_buf_en, .sbus_buf_dir(), .mbus_buf_en(), .mbus_buf_dir(), .xbus_buf_en(),
        .xbus_buf_dir(), .ext_buf_en, .ext_buf_dir(), .fast_sel(), .power_ok_in,
        .expansion_reset_out);
    dsbc_partner dsbc_partner_i (.pclk, .cmd_n, .tgt_a0, .tgt_wdata, .rd_lo, .rd_hi, .tgt_rdata,
        .wr_lo, .wr_hi);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) errors++;
        if (i == 20) give_verdict();
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    // c holds valid, fast, wide, write, io, word
    task automatic go(logic [5:0] c, logic [2:0] w, logic [1:0] d, logic [1:0] k, logic [15:0] a);
        @(posedge pclk);
        {fb_valid, fb_fast, fb_wide, cyc_write, cyc_io, cyc_word} <= c;
        {fb_waits, fb_delays, fb_kind, cyc_addr} <= {w, d, k, a};
        {cyc_wdata, rd_hi, rd_lo} <= $urandom();
        cyc_start <= 1'b1;
        {n, fall, len, ext} = '0;
        do begin
            @(posedge pclk);
            cyc_start <= 1'b0;
            #1;
            n++;
            if (!cmd_n && fall == 0) fall = n;
            if (!cmd_n) len++;
            if (!cmd_n) ok = io_addr_ok;
            ext |= {sbus_buf_en, ext_buf_en};
        end while (cyc_ready !== 1'b1 && n < 300);
        if (n == 300) errors++;
        if (n == 300) give_verdict();
        @(posedge pclk);
    endtask
    initial begin
        static logic [7:0] cfg [4] = '{8'h00, 8'h42, 8'h10, 8'h80};
        static logic [7:0] ra [3] = '{8'h24, 8'h48, 8'h04};
        {psel, penable, pwrite, paddr, pwdata, cyc_start, cyc_write, cyc_io, cyc_word} = '0;
        {cyc_addr, cyc_wdata, fb_valid, fb_fast, fb_wide, fb_waits, fb_delays} = '0;
        {fb_bus, fb_kind, rd_lo, rd_hi, presetn, power_ok_in} = 22'h1;
        void'($urandom(32'hfd4f));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 0);
            chk(rd, 0);
        end
        apb(1'b0, 8'h0c, 0);
        chk({err, rd[7:0]}, 9'h100);
        chk(expansion_reset_out, 0);
        apb(1'b1, 8'h24, 32'h04);
        repeat (3) @(posedge pclk);
        chk(expansion_reset_out, 1);
        apb(1'b1, 8'h24, 0);
        power_ok_in <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(expansion_reset_out, 1);
        power_ok_in <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(expansion_reset_out, 0);
        for (int i = 0; i < 4; i++) begin
            fb_bus <= 2'(i % 3);
            go(6'h39, 3'(i), 2'h0, 2'h0, 16'($urandom()));
            chk(n, 3 + i);
        end
        for (int i = 1; i < 3; i++) begin
            go(6'h39, 3'h0, 2'h0, 2'(i), 16'h0);
            chk(n, 4);
            apb(1'b1, 8'h48, 32'h40 << (i - 1));
            go(6'h39, 3'h0, 2'h0, 2'(i), 16'h0);
            chk(n, 3);
            apb(1'b1, 8'h48, 0);
        end
        go(6'h29, 3'h0, 2'h0, 2'h0, 16'h0);
        {f0, l0} = {fall, len};
        go(6'h29, 3'h0, 2'h1, 2'h0, 16'h0);
        f0 = fall - f0;
        go(6'h29, 3'h1, 2'h0, 2'h0, 16'h0);
        chk(f0 > 0 && f0 < 8, 1);
        chk(len - l0, 2 * 4);
        go(6'h01, 3'h0, 2'h0, 2'h0, 16'h0);
        chk(ext, 0);
        apb(1'b1, 8'h24, 1);
        go(6'h01, 3'h0, 2'h0, 2'h0, 16'h0);
        chk(ext, 3);
        for (int i = 0; i < 4; i++) begin
            go({3'h4, i[1], 1'b0, ~i[0]}, 3'h0, 2'h0, 2'h0, {15'($urandom()), i[0]});
            if (i[1]) chk(wr_hi, cyc_wdata[15:8]);
            else chk(cyc_rdata[15:8], rd_hi);
            if (i == 0) chk(cyc_rdata[7:0], rd_lo);
            if (i == 2) chk(wr_lo, cyc_wdata[7:0]);
        end
        go(6'h2b, 3'h0, 2'h0, 2'h0, {6'h3f, 10'($urandom())});
        chk(ok, 1);
        apb(1'b1, 8'h24, 32'h09);
        go(6'h2b, 3'h0, 2'h0, 2'h0, {6'h3f, 10'($urandom())});
        chk(ok, 0);
        foreach (cfg[i]) begin
            apb(1'b1, 8'h04, {24'h0, cfg[i]});
            apb(1'b0, 8'h80, 0);
            chk(rd[7:6], i);
            go(6'h29, 3'h0, 2'h1, 2'h0, 16'h0);
        end
        give_verdict();
    end
endmodule
